/* rtl/tss_pkg.sv */
package tss_pkg;

   // register offsets on the plain register port
   localparam logic [3:0]  TSS_CTRL_OFF     = 4'h0;
   localparam logic [3:0]  TSS_MASK_OFF     = 4'h4;
   localparam logic [3:0]  TSS_STAT_OFF     = 4'h8;

   // control field positions
   localparam int          TSS_DAC_SEL_LSB  = 0;
   localparam int          TSS_FAST_SEL_LSB = 3;
   localparam int          TSS_REF_SEL_LSB  = 6;
   localparam int          TSS_TDM_BIT      = 9;
   localparam int          TSS_CTRL_W       = 10;

   // status field positions
   localparam int          TSS_STAT_SLOT_LSB = 0;
   localparam int          TSS_STAT_RSV_BIT  = 4;
   localparam int          TSS_STAT_CNT_LSB  = 8;

   // values after reset: all groups at slot 1, tdm on, all slots masked
   localparam logic [9:0]  TSS_CTRL_RST     = 10'h200;
   localparam logic [31:0] TSS_MASK_RST     = 32'hFFFF_FFFF;

   // line two mask bits sit above the sixteen line one bits
   localparam int          TSS_MASK_TWO_LSB = 16;

   // slot geometry: 32-bit slots, 24-bit sample in the upper bits
   localparam int          TSS_SLOT_BITS    = 32;
   localparam int          TSS_SAMPLE_BITS  = 24;
   localparam logic [3:0]  TSS_LAST_SLOT    = 4'hF;
   localparam logic [1:0]  TSS_LAST_LANE    = 2'h3;
   localparam logic [1:0]  TSS_LSB_LANE     = 2'h2;
   localparam logic [4:0]  TSS_BIT_LAST     = 5'h1F;

   // reference dac source codes
   typedef enum logic [2:0] {
      TSS_REF_GRP1   = 3'h0,
      TSS_REF_GRP2   = 3'h1,
      TSS_REF_GRP3   = 3'h2,
      TSS_REF_GRP4   = 3'h3,
      TSS_REF_MASKED = 3'h4
   } tss_ref_code_t;

   // magnitude of a two's complement sample
   function automatic logic [23:0] tss_mag(input logic [23:0] s);
      return s[23] ? (~s + 24'h000001) : s;
   endfunction : tss_mag

endpackage : tss_pkg

/* rtl/tss_slot_deser.sv */
`timescale 1ns/10ps
module tss_slot_deser
   import tss_pkg::*;
(
   input  wire logic        link_sclk,
   input  wire logic        rst_b,
   input  wire logic        frame_sync,
   input  wire logic        line_one,
   input  wire logic        line_two,
   output logic [31:0]      word_one,
   output logic [31:0]      word_two,
   output logic [3:0]       slot,
   output logic             toggle
);

   logic        rs1_reg;
   logic        rs2_reg;
   logic        rs3_reg;
   logic        fs_prev_reg;
   logic [8:0]  cnt_reg;
   logic [30:0] sh_one_reg;
   logic [30:0] sh_two_reg;
   wire         lrst_b;
   wire         fs_rise;
   wire  [8:0]  cur_cnt;
   wire         word_done;

   // reset brought onto the bit clock; the clock only runs with frames
   always_ff @(posedge link_sclk) begin
      rs1_reg <= rst_b;
      rs2_reg <= rs1_reg;
      rs3_reg <= rs2_reg;
   end
   assign lrst_b = rs3_reg;

   // frame starts on a rising frame sync, first bit on the same edge
   assign fs_rise   = frame_sync & ~fs_prev_reg;
   assign cur_cnt   = fs_rise ? 9'h000 : cnt_reg;
   assign word_done = (cur_cnt[4:0] == TSS_BIT_LAST);

   // bit counter and shifters, msb first
   always_ff @(posedge link_sclk) begin
      if (!lrst_b) begin
         fs_prev_reg <= 1'b0;
         cnt_reg     <= 9'h000;
         sh_one_reg  <= 31'h0000_0000;
         sh_two_reg  <= 31'h0000_0000;
      end else begin
         fs_prev_reg <= frame_sync;
         cnt_reg     <= cur_cnt + 9'h001;
         sh_one_reg  <= {sh_one_reg[29:0], line_one};
         sh_two_reg  <= {sh_two_reg[29:0], line_two};
      end
   end

   // words held a whole slot, long enough for the core to fetch them
   always_ff @(posedge link_sclk) begin
      if (!lrst_b) begin
         word_one <= 32'h0000_0000;
         word_two <= 32'h0000_0000;
         slot     <= 4'h0;
         toggle   <= 1'b0;
      end else if (word_done) begin
         word_one <= {sh_one_reg, line_one};
         word_two <= {sh_two_reg, line_two};
         slot     <= cur_cnt[8:5];
         toggle   <= ~toggle;
      end
   end

endmodule : tss_slot_deser

/* rtl/tss_source_select.sv */
// What this block does
// - reference codes 0-3 take the sample from slot lsbs 1-3,5-7,9-11,13-15
// - code 4 uses per-slot mask bits; codes 5-7 reserved, output frozen
// - fast path code picks four-slot group; codes 4-7 use line two
// - audio dac code picks one of four four-slot groups on either line
// - three slot bytes form reference sample, first slot highest byte
// - outside tdm, line one feeds dacs one/two, line two three/four
`timescale 1ns/10ps
module tss_source_select
   import tss_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   input  wire logic [3:0]        bus_addr,
   input  wire logic [31:0]       bus_wdata,
   input  wire logic              bus_wr,
   input  wire logic              bus_rd,
   output logic      [31:0]       bus_rdata,
   input  wire logic              link_sclk,
   input  wire logic              frame_sync,
   input  wire logic              tdm_input_line_one,
   input  wire logic              tdm_input_line_two,
   output logic      [3:0][23:0]  audio_dac_sample,
   output logic                   audio_dac_update,
   output logic      [3:0][23:0]  fast_path_sample,
   output logic                   fast_path_update,
   output logic      [23:0]       reference_dac_sample,
   output logic                   reference_dac_update
);

   logic [TSS_CTRL_W-1:0] ctrl_reg;
   logic [31:0]           mask_reg;
   logic                  tog_s1_reg;
   logic                  tog_s2_reg;
   logic                  tog_s3_reg;
   logic [7:0]            ref_cnt_reg;
   logic                  rsv_seen_reg;
   logic [3:0]            last_slot_reg;
   logic [7:0]            ref_hi_reg;
   logic [7:0]            ref_mid_reg;
   logic [23:0]           peak_smp_reg;
   logic [23:0]           peak_mag_reg;
   logic [31:0]           rdata_next;
   wire  [31:0]           lk_word_one;
   wire  [31:0]           lk_word_two;
   wire  [3:0]            lk_slot;
   wire                   lk_toggle;

   // bit clock side: slot words of both lines with their index
   tss_slot_deser u_deser (
      .link_sclk (link_sclk),
      .rst_b     (rst_b),
      .frame_sync(frame_sync),
      .line_one  (tdm_input_line_one),
      .line_two  (tdm_input_line_two),
      .word_one  (lk_word_one),
      .word_two  (lk_word_two),
      .slot      (lk_slot),
      .toggle    (lk_toggle)
   );

   // slot event crossing: toggle through three flops, edge of 2nd vs 3rd
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tog_s1_reg <= 1'b0;
         tog_s2_reg <= 1'b0;
         tog_s3_reg <= 1'b0;
      end else begin
         tog_s1_reg <= lk_toggle;
         tog_s2_reg <= tog_s1_reg;
         tog_s3_reg <= tog_s2_reg;
      end
   end

   // words are held a full slot on the far side, so read them directly
   wire         slot_ev   = tog_s2_reg ^ tog_s3_reg;
   wire [1:0]   lane      = lk_slot[1:0];
   wire [1:0]   grp       = lk_slot[3:2];
   wire         tdm_on    = ctrl_reg[TSS_TDM_BIT];
   wire [2:0]   dac_sel   = ctrl_reg[TSS_DAC_SEL_LSB +: 3];
   wire [2:0]   fast_sel  = ctrl_reg[TSS_FAST_SEL_LSB +: 3];
   wire [2:0]   ref_sel   = ctrl_reg[TSS_REF_SEL_LSB +: 3];
   wire [23:0]  smp_one   = lk_word_one[31:8];
   wire [23:0]  smp_two   = lk_word_two[31:8];

   // group decode for the audio dac and fast paths
   wire [23:0]  dac_src   = dac_sel[2] ? smp_two : smp_one;
   wire         dac_hit   = slot_ev & tdm_on & (grp == dac_sel[1:0]);
   wire [23:0]  fast_src  = fast_sel[2] ? smp_two : smp_one;
   wire         fast_hit  = slot_ev & tdm_on & (grp == fast_sel[1:0]);
   wire         last_lane = (lane == TSS_LAST_LANE);

   // reference decode: fixed three-slot groups, masks, or reserved
   wire         ref_fixed = ~ref_sel[2];
   wire         ref_mmode = (ref_sel == TSS_REF_MASKED);
   wire         ref_rsv   = ref_sel[2] & (ref_sel[1:0] != 2'h0);
   wire         ref_hit   = slot_ev & tdm_on & ref_fixed
                            & (grp == ref_sel[1:0]) & ~last_lane;
   wire         ref_done  = ref_hit & (lane == TSS_LSB_LANE);
   wire [23:0]  ref_word  = {ref_hi_reg, ref_mid_reg,
                             lk_word_one[7:0]};

   // mask mode: a zero bit lets the slot in; loudest slot wins
   wire [4:0]   idx_two   = {1'b1, lk_slot};
   wire         open_one  = ~mask_reg[{1'b0, lk_slot}];
   wire         open_two  = ~mask_reg[idx_two];
   wire         mask_hit  = slot_ev & tdm_on & ref_mmode;
   wire         mask_end  = mask_hit & (lk_slot == TSS_LAST_SLOT);
   wire [23:0]  mag_one   = tss_mag(smp_one);
   wire [23:0]  mag_two   = tss_mag(smp_two);
   wire         take_one  = open_one & (mag_one > peak_mag_reg);
   wire [23:0]  mid_mag   = take_one ? mag_one : peak_mag_reg;
   wire [23:0]  mid_smp   = take_one ? smp_one : peak_smp_reg;
   wire         take_two  = open_two & (mag_two > mid_mag);
   wire [23:0]  best_mag  = take_two ? mag_two : mid_mag;
   wire [23:0]  best_smp  = take_two ? smp_two : mid_smp;

   // two-channel framing: slot 0 left, slot 1 right
   wire         pcm_hit   = slot_ev & ~tdm_on & (lk_slot[3:1] == 3'h0);

   // register port decode
   wire         wr_ctrl   = bus_wr & (bus_addr == TSS_CTRL_OFF);
   wire         wr_mask   = bus_wr & (bus_addr == TSS_MASK_OFF);
   wire [31:0]  stat_word = {16'h0000, ref_cnt_reg, 3'h0, rsv_seen_reg,
                             last_slot_reg}; // core copy, never mid-change

   // control and mask registers
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ctrl_reg <= TSS_CTRL_RST;
         mask_reg <= TSS_MASK_RST;
      end else begin
         if (wr_ctrl) ctrl_reg <= bus_wdata[TSS_CTRL_W-1:0];
         if (wr_mask) mask_reg <= bus_wdata;
      end
   end

   // read data stand only in the cycle after the strobe
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (bus_rd) begin
         case (bus_addr)
            TSS_CTRL_OFF: rdata_next = {22'h000000, ctrl_reg};
            TSS_MASK_OFF: rdata_next = mask_reg;
            TSS_STAT_OFF: rdata_next = stat_word;
            default:      rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) bus_rdata <= 32'h0000_0000;
      else        bus_rdata <= rdata_next;
   end

   // audio dac path: group lane n feeds channel n, pcm routing otherwise
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         audio_dac_sample <= '0;
         audio_dac_update <= 1'b0;
      end else begin
         audio_dac_update <= (dac_hit & last_lane) |
                             (pcm_hit & lk_slot[0]);
         if (dac_hit) audio_dac_sample[lane] <= dac_src;
         if (pcm_hit) begin
            audio_dac_sample[{1'b0, lk_slot[0]}] <= smp_one;
            audio_dac_sample[{1'b1, lk_slot[0]}] <= smp_two;
         end
      end
   end

   // fast path; idle outside tdm since it has no pcm routing
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         fast_path_sample <= '0;
         fast_path_update <= 1'b0;
      end else begin
         fast_path_update <= fast_hit & last_lane;
         if (fast_hit) fast_path_sample[lane] <= fast_src;
      end
   end

   // reference bytes gathered in slot order, published on the third
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ref_hi_reg  <= 8'h00;
         ref_mid_reg <= 8'h00;
      end else if (ref_hit) begin
         if (lane == 2'h0) ref_hi_reg  <= lk_word_one[7:0];
         if (lane == 2'h1) ref_mid_reg <= lk_word_one[7:0];
      end
   end

   // peak over unmasked slots, cleared at each frame end
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         peak_smp_reg <= 24'h000000;
         peak_mag_reg <= 24'h000000;
      end else if (mask_end | ~ref_mmode) begin
         peak_smp_reg <= 24'h000000;
         peak_mag_reg <= 24'h000000;
      end else if (mask_hit) begin
         peak_smp_reg <= best_smp;
         peak_mag_reg <= best_mag;
      end
   end

   // reference output; reserved codes freeze it rather than guess
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         reference_dac_sample <= 24'h000000;
         reference_dac_update <= 1'b0;
      end else begin
         reference_dac_update <= ref_done | mask_end;
         if (ref_done)      reference_dac_sample <= ref_word;
         else if (mask_end) reference_dac_sample <= best_smp;
      end
   end

   // status: updates counted, reserved code flagged while programmed
   // slot index copied on the event, while the link side holds it steady
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ref_cnt_reg   <= 8'h00;
         rsv_seen_reg  <= 1'b0;
         last_slot_reg <= 4'h0;
      end else begin
         rsv_seen_reg <= ref_rsv;
         if (slot_ev) last_slot_reg <= lk_slot;
         if (ref_done | mask_end) ref_cnt_reg <= ref_cnt_reg + 8'h01;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_ref_last_byte;
      slot_ev & tdm_on & ref_fixed & (grp == ref_sel[1:0])
         & (lane == TSS_LSB_LANE);
   endsequence

   sequence s_ref_published;
      reference_dac_update ##0
         (reference_dac_sample == {$past(ref_hi_reg), $past(ref_mid_reg),
                                   $past(lk_word_one[7:0])});
   endsequence

   a_ref_three_slot: assert property (
      s_ref_last_byte |=> s_ref_published)
      else $error("reference sample not packed from three slots");

   a_ref_byte_order: assert property (
      ref_hit & (lane == 2'h0) |=> ref_hi_reg == $past(lk_word_one[7:0]))
      else $error("first slot byte not in top position");

   a_ref_mid_byte: assert property (
      ref_hit & (lane == 2'h1) |=> ref_mid_reg == $past(lk_word_one[7:0]))
      else $error("second slot byte not in middle position");

   a_ref_reserved: assert property (
      slot_ev & ref_rsv |=> !reference_dac_update
                            && $stable(reference_dac_sample))
      else $error("reserved reference code changed output");

   a_ref_mask_end: assert property (
      mask_hit & (lk_slot != TSS_LAST_SLOT) |=> !reference_dac_update)
      else $error("mask mode published before last slot");

   a_ref_mask_only: assert property (
      mask_end & !open_one & !open_two & (peak_mag_reg == 24'h000000)
      |=> reference_dac_update && reference_dac_sample == 24'h000000)
      else $error("masked slots reached reference");

   a_fast_group: assert property (
      fast_hit |=> fast_path_sample[$past(lane)] == $past(fast_src))
      else $error("fast path took wrong slot");

   a_fast_line_two: assert property (
      fast_hit & fast_sel[2] |=> fast_path_sample[$past(lane)]
                                 == $past(smp_two))
      else $error("fast path codes 4-7 not on line two");

   a_dac_group: assert property (
      dac_hit |=> audio_dac_sample[$past(lane)] == $past(dac_src))
      else $error("audio dac took wrong slot");

   a_dac_hold: assert property (
      slot_ev & tdm_on & (grp != dac_sel[1:0])
      |=> $stable(audio_dac_sample) && !audio_dac_update)
      else $error("audio dac changed outside its group");

   // line choice spelled out so a line two group is checked as well
   a_lane_order: assert property (
      dac_hit & last_lane |=> audio_dac_update
                              && audio_dac_sample[3] == ($past(dac_sel[2])
                                 ? $past(smp_two) : $past(smp_one)))
      else $error("fourth slot not on channel four");

   a_pcm_route: assert property (
      pcm_hit & (lk_slot == 4'h0) |=> audio_dac_sample[0] == $past(smp_one)
                                      && audio_dac_sample[2] == $past(smp_two))
      else $error("two-channel routing wrong");

   a_pcm_no_fast: assert property (
      slot_ev & !tdm_on |=> !fast_path_update && !reference_dac_update)
      else $error("slot paths active outside tdm");

endmodule : tss_source_select

/* verif/test_tss_source_select.sv */
`timescale 1ns/10ps
module test_tss_source_select
   import tss_pkg::*;
;
   logic              core_clk;
   logic              rst_b;
   logic [3:0]        bus_addr;
   logic [31:0]       bus_wdata;
   logic              bus_wr;
   logic              bus_rd;
   logic [31:0]       bus_rdata;
   wire               link_sclk;
   wire               frame_sync;
   wire               line_one;
   wire               line_two;
   logic [3:0][23:0]  audio_dac_sample;
   logic [3:0][23:0]  fast_path_sample;
   logic [23:0]       reference_dac_sample;
   logic              audio_dac_update;
   logic              fast_path_update;
   logic              reference_dac_update;
   int                bad_count;
   int                n_compared;
   int                n_aud;
   int                n_fast;
   int                n_ref;
   logic [31:0]       rd;
   logic [2:0]        aud;
   logic [2:0]        fst;
   logic [2:0]        ref_c;

   tss_tdm_model dsp (.link_sclk(link_sclk), .frame_sync(frame_sync),
      .line_one(line_one), .line_two(line_two));

   tss_source_select DUT (.core_clk(core_clk), .rst_b(rst_b),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata), .link_sclk(link_sclk),
      .frame_sync(frame_sync), .tdm_input_line_one(line_one),
      .tdm_input_line_two(line_two), .audio_dac_sample(audio_dac_sample),
      .audio_dac_update(audio_dac_update),
      .fast_path_sample(fast_path_sample),
      .fast_path_update(fast_path_update),
      .reference_dac_sample(reference_dac_sample),
      .reference_dac_update(reference_dac_update));

   initial core_clk = 1'b0;
   always #5 core_clk = ~core_clk;

   // count update pulses so each frame can be judged by its pulse count
   always @(posedge core_clk) begin
      if (audio_dac_update === 1'b1) n_aud <= n_aud + 1;
      if (fast_path_update === 1'b1) n_fast <= n_fast + 1;
      if (reference_dac_update === 1'b1) n_ref <= n_ref + 1;
   end

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict

   task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge core_clk);
      bus_wr    <= 1'b0;
   endtask : bus_write

   // read data stands only in the cycle after the strobe
   task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge core_clk);
      bus_rd   <= 1'b0;
      #1;
      d = bus_rdata;
   endtask : bus_read

   function automatic logic [23:0] smp(input int ln, input int s);
      logic [31:0] w;
      w = dsp.pat(ln, s);
      return w[31:8];
   endfunction : smp

   function automatic logic [23:0] ref_exp(input int g);
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] c;
      a = dsp.pat(1, 4 * g + 1);
      b = dsp.pat(1, 4 * g + 2);
      c = dsp.pat(1, 4 * g + 3);
      return {a[7:0], b[7:0], c[7:0]};
   endfunction : ref_exp

   task automatic chk_group(input string what, input logic [3:0][23:0] seen,
                            input logic [2:0] code);
      for (int k = 0; k < 4; k++) begin
         chk(what, 32'(seen[k]),
             32'(smp(code[2] ? 2 : 1, 4 * code[1:0] + k + 1)));
      end
   endtask : chk_group

   // frame plus settling time for the crossing into the core domain
   task automatic run_frame(input int nslots);
      n_aud  = 0;
      n_fast = 0;
      n_ref  = 0;
      dsp.send_frame(nslots);
      repeat (20) @(posedge core_clk);
      #1;
   endtask : run_frame

   // watchdog: twelve frames take well under this span
   initial begin
      #900us;
      bad_count++;
      $display("watchdog expired");
      print_verdict();
   end

   initial begin
      rst_b      = 1'b0;
      bus_addr   = 4'h0;
      bus_wdata  = 32'h0;
      bus_wr     = 1'b0;
      bus_rd     = 1'b0;
      bad_count  = 0;
      n_compared = 0;
      // link side needs its own clock edges while reset is held
      fork
         repeat (16) @(posedge core_clk);
         dsp.idle_clocks(6);
      join
      @(posedge core_clk);
      rst_b <= 1'b1;
      dsp.idle_clocks(6);
      chk("ref at reset", 32'(reference_dac_sample), 32'h0);
      chk("dac at reset", 32'(audio_dac_sample[0]), 32'h0);
      bus_read(TSS_CTRL_OFF, rd);
      chk("ctrl reset", rd, 32'(TSS_CTRL_RST));
      bus_read(TSS_MASK_OFF, rd);
      chk("mask reset", rd, TSS_MASK_RST);
      bus_write(4'hC, 32'hFFFF_FFFF);
      bus_read(4'hC, rd);
      chk("unmapped", rd, 32'h0);
      // every audio and fast code, each reference group code twice
      for (int c = 0; c < 8; c++) begin
         aud   = 3'(c);
         fst   = 3'(7 - c);
         ref_c = 3'(c % 4);
         bus_write(TSS_CTRL_OFF, {22'h0, 1'b1, ref_c, fst, aud});
         run_frame(16);
         chk_group("audio", audio_dac_sample, aud);
         chk_group("fast", fast_path_sample, fst);
         chk("reference", 32'(reference_dac_sample),
             32'(ref_exp(c % 4)));
         chk("pulses", 32'(n_aud * 100 + n_fast * 10 + n_ref), 32'h0000_006F);
      end
      bus_read(TSS_STAT_OFF, rd);
      chk("status", 32'({rd[15:8], 3'h0, rd[4:0]}),
          32'({8'h08, 3'h0, 1'b0, TSS_LAST_SLOT}));
      // reserved reference codes flag status and freeze the output
      for (int r = 5; r < 8; r++) begin
         bus_write(TSS_CTRL_OFF, {22'h0, 1'b1, 3'(r), 3'h0, 3'h7});
         bus_read(TSS_STAT_OFF, rd);
         chk("reserved flag", 32'(rd[4]), 32'h1);
      end
      run_frame(16);
      chk("frozen ref", 32'(reference_dac_sample), 32'(ref_exp(3)));
      chk("frozen pulses", 32'(n_ref), 32'h0);
      // mask mode: line one slot 2 and line two slot 3 unmasked
      bus_write(TSS_MASK_OFF, 32'hFFFB_FFFD);
      bus_write(TSS_CTRL_OFF, {22'h0, 1'b1, 3'h4, 3'h0, 3'h7});
      bus_read(TSS_STAT_OFF, rd);
      chk("mask flag", 32'(rd[4]), 32'h0);
      run_frame(16);
      chk("masked ref", 32'(reference_dac_sample), 32'(smp(2, 3)));
      chk("masked pulses", 32'(n_ref), 32'h1);
      // every slot masked again: the reference must fall back to zero
      bus_write(TSS_MASK_OFF, TSS_MASK_RST);
      run_frame(16);
      chk("all masked ref", 32'(reference_dac_sample), 32'h0);
      chk("all masked pulses", 32'(n_ref), 32'h1);
      // two-channel mode: slot selection no longer applies
      bus_write(TSS_CTRL_OFF, 32'h0000_0007);
      run_frame(2);
      chk("pcm ch1", 32'(audio_dac_sample[0]), 32'(smp(1, 1)));
      chk("pcm ch2", 32'(audio_dac_sample[1]), 32'(smp(1, 2)));
      chk("pcm ch3", 32'(audio_dac_sample[2]), 32'(smp(2, 1)));
      chk("pcm ch4", 32'(audio_dac_sample[3]), 32'(smp(2, 2)));
      chk("pcm pulses", 32'(n_aud * 10 + n_fast), 32'h0000_000A);
      print_verdict();
   end
endmodule : test_tss_source_select

/* verif/tss_tdm_model.sv */
`timescale 1ns/10ps
// serial controller feeding two tdm lines; its bit clock stops between frames
module tss_tdm_model (
   output logic link_sclk,
   output logic frame_sync,
   output logic line_one,
   output logic line_two
);
   localparam time HALF = 40ns;

   // slot pattern: top byte names line and slot, low byte carries ref bytes
   function automatic logic [31:0] pat(input int ln, input int s);
      return {8'(ln * 16 + s), 8'(8'hA5 ^ s), 8'(s * 3),
              8'(8'h80 + ln * 16 + s)};
   endfunction : pat

   initial begin
      link_sclk  = 1'b0;
      frame_sync = 1'b0;
      line_one   = 1'b0;
      line_two   = 1'b0;
   end

   // free clocks for the link reset; lines toggle so nothing looks valid
   task automatic idle_clocks(input int n);
      #3;
      repeat (n) begin
         line_one = ~line_one;
         line_two = ~line_two;
         #HALF link_sclk = 1'b1;
         #HALF link_sclk = 1'b0;
      end
   endtask : idle_clocks

   // one frame, msb first, sync high through slot one
   task automatic send_frame(input int nslots);
      logic [31:0] w1;
      logic [31:0] w2;
      #3;
      for (int s = 1; s <= nslots; s++) begin
         w1 = pat(1, s);
         w2 = pat(2, s);
         for (int b = 31; b >= 0; b--) begin
            frame_sync = (s == 1);
            line_one   = w1[b];
            line_two   = w2[b];
            #HALF link_sclk = 1'b1;
            #HALF link_sclk = 1'b0;
         end
      end
      // released lines show the inverse of the last bit
      frame_sync = 1'b0;
      line_one   = ~line_one;
      line_two   = ~line_two;
   endtask : send_frame
endmodule : tss_tdm_model
